// *** include/clk_ctl_map.svh ***
// Register addresses, field masks and reset values of the clock control block
`ifndef CLK_CTL_MAP_SVH
`define CLK_CTL_MAP_SVH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define GATE_ZERO_ADDR 32'h4000_00C0
`define GATE_ONE_ADDR 32'h4000_00C4
`define GATE_ZERO_SET_ADDR 32'h4000_00C8
`define GATE_ONE_SET_ADDR 32'h4000_00CC
`define GATE_ZERO_CLR_ADDR 32'h4000_00D0
`define GATE_ONE_CLR_ADDR 32'h4000_00D4
`define TICK_DIV_ADDR 32'h4000_00E0
`define SYS_DIV_ADDR 32'h4000_0100
`define CONV_DIV_ADDR 32'h4000_0108
`define EXTERNAL_CLOCK_OUTPUT_DIV_ADDR 32'h4000_010C

// ----------------------------------------------------------------
// Implemented gate bits and reset values
// ----------------------------------------------------------------
`define GATE_ZERO_MASK 32'h0CFC_E99A
`define GATE_ONE_MASK 32'h0C40_0607
`define GATE_ZERO_RESET 32'h0000_018B
`define GATE_ONE_RESET 32'h0000_0000

// ----------------------------------------------------------------
// Divider reset values
// ----------------------------------------------------------------
`define TICK_DIV_RESET 8'h00
`define SYS_DIV_RESET 8'h01
`define CONV_DIV_RESET 8'h00
`define EXTERNAL_CLOCK_OUTPUT_DIV_RESET 8'h00

`endif

// *** include/clk_ctl_pkg.sv ***
// Types shared by the clock control block
package clk_ctl_pkg;
    typedef logic [7:0] div_t;
    typedef enum logic [1:0] {
        resp_okay = 2'h0,
        resp_slverr = 2'h2
    } resp_e;
endpackage

// *** include/div_if.sv ***
// Divisor and tick between the register block and one divider
`timescale 1ns/1ps
interface div_if;
    clk_ctl_pkg::div_t divisor;
    logic tick;
    modport ctl (output divisor, input tick);
    modport gen (input divisor, output tick);
endinterface

// *** hdl/clock_divider.sv ***
// One 8-bit clock divider producing a tick enable every N cycles
`timescale 1ns/1ps
module clock_divider (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Divisor in, tick out
    div_if.gen dv
);
    clk_ctl_pkg::div_t active_q;
    clk_ctl_pkg::div_t active_d;
    clk_ctl_pkg::div_t cnt_q;
    clk_ctl_pkg::div_t cnt_d;
    logic tick_q;
    logic idle;
    logic wrap;

    // ----------------------------------------------------------------
    // Counting, new divisor taken at a period boundary or while stopped
    // ----------------------------------------------------------------
    assign idle = (active_q == 8'h00);
    assign wrap = !idle && (cnt_q == active_q - 8'h01);
    assign active_d = (idle || wrap) ? dv.divisor : active_q;
    assign cnt_d = (idle || wrap) ? 8'h00 : cnt_q + 8'h01;
    assign dv.tick = tick_q;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            active_q <= 8'h00;
            cnt_q <= 8'h00;
            tick_q <= 1'b0;
        end else begin
            active_q <= active_d;
            cnt_q <= cnt_d;
            tick_q <= wrap;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_stopped_quiet: assert property (@(posedge clk_sys) disable iff (rst)
        idle |=> !tick_q)
        else $error("divider ticked while stopped");
    a_tick_cause: assert property (@(posedge clk_sys) disable iff (rst)
        tick_q |-> ($past(active_q) != 8'h00) && ($past(cnt_q) == $past(active_q) - 8'h01))
        else $error("tick not at end of period");
    a_no_short_pulse: assert property (@(posedge clk_sys) disable iff (rst)
        tick_q && (active_q > 8'h01) |=> !tick_q)
        else $error("tick spacing shorter than period");
endmodule

// *** hdl/peripheral_clock_gate_and_dividers.sv ***
// Peripheral clock gates with set and clear companions and four clock dividers
`timescale 1ns/1ps
`include "clk_ctl_map.svh"
module peripheral_clock_gate_and_dividers (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Write address channel
    input wire logic [31:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    // Write data channel
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // Write response channel
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // Read address channel
    input wire logic [31:0] araddr,
    input wire logic arvalid,
    output logic arready,
    // Read data channel
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Gate outputs
    output logic [31:0] gate_zero,
    output logic [31:0] gate_one,
    // Divided clock enables
    output logic tick_timer_clk_en,
    output logic sys_clk_en,
    output logic converter_clk_en,
    output logic external_clock_output
);

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    function automatic logic [9:0] reg_decode(input logic [31:0] addr);
        reg_decode = {
            addr == `EXTERNAL_CLOCK_OUTPUT_DIV_ADDR,
            addr == `CONV_DIV_ADDR,
            addr == `SYS_DIV_ADDR,
            addr == `TICK_DIV_ADDR,
            addr == `GATE_ONE_CLR_ADDR,
            addr == `GATE_ZERO_CLR_ADDR,
            addr == `GATE_ONE_SET_ADDR,
            addr == `GATE_ZERO_SET_ADDR,
            addr == `GATE_ONE_ADDR,
            addr == `GATE_ZERO_ADDR
        };
    endfunction

    // ----------------------------------------------------------------
    // Write channel state
    // ----------------------------------------------------------------
    logic awready_q;
    logic awready_d;
    logic wready_q;
    logic wready_d;
    logic aw_held_q;
    logic aw_held_d;
    logic w_held_q;
    logic w_held_d;
    logic [31:0] waddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic bvalid_q;
    logic bvalid_d;
    logic [1:0] bresp_q;
    logic [1:0] bresp_d;
    logic aw_take;
    logic w_take;
    logic do_write;
    logic [9:0] wsel;
    logic [31:0] wbits;

    assign aw_take = awvalid && awready_q;
    assign w_take = wvalid && wready_q;
    assign do_write = aw_held_q && w_held_q && !bvalid_q;
    assign aw_held_d = (aw_held_q || aw_take) && !do_write;
    assign w_held_d = (w_held_q || w_take) && !do_write;
    assign bvalid_d = do_write || (bvalid_q && !bready);
    assign awready_d = !aw_held_d && !bvalid_d;
    assign wready_d = !w_held_d && !bvalid_d;
    assign wsel = do_write ? reg_decode(waddr_q) : 10'h000;
    assign bresp_d = !do_write ? bresp_q
        : (wsel == 10'h000) ? clk_ctl_pkg::resp_slverr : clk_ctl_pkg::resp_okay;

    // Byte lanes without strobe count as zero
    generate
        for (genvar i = 0; i < 4; i++) begin : g_lane
            assign wbits[i*8 +: 8] = wdata_q[i*8 +: 8] & {8{wstrb_q[i]}};
        end
    endgenerate

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= 2'h0;
        end else begin
            awready_q <= awready_d;
            wready_q <= wready_d;
            aw_held_q <= aw_held_d;
            w_held_q <= w_held_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            waddr_q <= 32'h0000_0000;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
        end else begin
            if (aw_take) begin
                waddr_q <= awaddr;
            end
            if (w_take) begin
                wdata_q <= wdata;
                wstrb_q <= wstrb;
            end
        end
    end

    // ----------------------------------------------------------------
    // Gate registers with set and clear companions
    // ----------------------------------------------------------------
    logic [31:0] gate_zero_q;
    logic [31:0] gate_zero_d;
    logic [31:0] gate_one_q;
    logic [31:0] gate_one_d;
    logic [31:0] bits_zero;
    logic [31:0] bits_one;

    assign bits_zero = wbits & `GATE_ZERO_MASK;
    assign bits_one = wbits & `GATE_ONE_MASK;
    assign gate_zero_d = wsel[0] ? ((gate_zero_q & ~`GATE_ZERO_MASK) | bits_zero)
        : wsel[2] ? (gate_zero_q | bits_zero)
        : wsel[4] ? (gate_zero_q & ~bits_zero)
        : gate_zero_q;
    assign gate_one_d = wsel[1] ? ((gate_one_q & ~`GATE_ONE_MASK) | bits_one)
        : wsel[3] ? (gate_one_q | bits_one)
        : wsel[5] ? (gate_one_q & ~bits_one)
        : gate_one_q;
    assign gate_zero = gate_zero_q;
    assign gate_one = gate_one_q;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            gate_zero_q <= `GATE_ZERO_RESET;
            gate_one_q <= `GATE_ONE_RESET;
        end else begin
            gate_zero_q <= gate_zero_d;
            gate_one_q <= gate_one_d;
        end
    end

    // ----------------------------------------------------------------
    // Divider registers and divider instances
    // ----------------------------------------------------------------
    localparam clk_ctl_pkg::div_t DIV_RESET [4] = '{
        `TICK_DIV_RESET, `SYS_DIV_RESET, `CONV_DIV_RESET, `EXTERNAL_CLOCK_OUTPUT_DIV_RESET
    };
    clk_ctl_pkg::div_t div_q [4];
    logic [3:0] tick;

    generate
        for (genvar k = 0; k < 4; k++) begin : g_div
            clk_ctl_pkg::div_t div_d;
            div_if dv ();
            // Only the low byte lane carries the divisor
            assign div_d = (wsel[6 + k] && wstrb_q[0]) ? wdata_q[7:0] : div_q[k];
            assign dv.divisor = div_q[k];
            assign tick[k] = dv.tick;
            always_ff @(posedge clk_sys or posedge rst) begin
                if (rst) begin
                    div_q[k] <= DIV_RESET[k];
                end else begin
                    div_q[k] <= div_d;
                end
            end
            clock_divider u_div (
                .clk_sys(clk_sys),
                .rst(rst),
                .dv(dv.gen)
            );
        end
    endgenerate

    assign tick_timer_clk_en = tick[0];
    assign sys_clk_en = tick[1];
    assign converter_clk_en = tick[2];
    assign external_clock_output = tick[3];

    // ----------------------------------------------------------------
    // Read channel
    // ----------------------------------------------------------------
    logic arready_q;
    logic arready_d;
    logic rvalid_q;
    logic rvalid_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic [1:0] rresp_q;
    logic [1:0] rresp_d;
    logic ar_take;
    logic [9:0] rsel;
    logic [31:0] rd_mux;

    assign ar_take = arvalid && arready_q;
    assign rsel = reg_decode(araddr);
    assign rvalid_d = ar_take || (rvalid_q && !rready);
    assign arready_d = !rvalid_d;
    // Set and clear registers read as zero, reserved divider bits as zero
    assign rd_mux = ({32{rsel[0]}} & gate_zero_q)
        | ({32{rsel[1]}} & gate_one_q)
        | ({32{rsel[6]}} & {24'h00_0000, div_q[0]})
        | ({32{rsel[7]}} & {24'h00_0000, div_q[1]})
        | ({32{rsel[8]}} & {24'h00_0000, div_q[2]})
        | ({32{rsel[9]}} & {24'h00_0000, div_q[3]});
    assign rdata_d = ar_take ? rd_mux : rdata_q;
    assign rresp_d = !ar_take ? rresp_q
        : (rsel == 10'h000) ? clk_ctl_pkg::resp_slverr : clk_ctl_pkg::resp_okay;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= 2'h0;
        end else begin
            arready_q <= arready_d;
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
        end
    end

    assign awready = awready_q;
    assign wready = wready_q;
    assign bvalid = bvalid_q;
    assign bresp = bresp_q;
    assign arready = arready_q;
    assign rvalid = rvalid_q;
    assign rdata = rdata_q;
    assign rresp = rresp_q;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_set_one_bits: assert property (@(posedge clk_sys) disable iff (rst)
        wsel[3] |=> gate_one_q == ($past(gate_one_q) | ($past(wbits) & `GATE_ONE_MASK)))
        else $error("group one set write wrong");
    a_clear_zero_bits: assert property (@(posedge clk_sys) disable iff (rst)
        wsel[4] |=> gate_zero_q == ($past(gate_zero_q) & ~($past(wbits) & `GATE_ZERO_MASK)))
        else $error("group zero clear write wrong");
    a_clear_one_bits: assert property (@(posedge clk_sys) disable iff (rst)
        wsel[5] |=> gate_one_q == ($past(gate_one_q) & ~($past(wbits) & `GATE_ONE_MASK)))
        else $error("group one clear write wrong");
    a_set_zero_bits: assert property (@(posedge clk_sys) disable iff (rst)
        wsel[2] |=> gate_zero_q == ($past(gate_zero_q) | ($past(wbits) & `GATE_ZERO_MASK)))
        else $error("group zero set write wrong");
    a_unused_gate_fixed: assert property (@(posedge clk_sys) disable iff (rst)
        ((gate_zero_q & ~`GATE_ZERO_MASK) == (`GATE_ZERO_RESET & ~`GATE_ZERO_MASK))
        && ((gate_one_q & ~`GATE_ONE_MASK) == 32'h0000_0000))
        else $error("unimplemented gate bit changed");
    a_wo_read_zero: assert property (@(posedge clk_sys) disable iff (rst)
        ar_take && (|rsel[5:2]) && !do_write |=> (rdata_q == 32'h0000_0000)
        && $stable(gate_zero_q) && $stable(gate_one_q))
        else $error("write-only register read not zero");
    a_div_resv_zero: assert property (@(posedge clk_sys) disable iff (rst)
        ar_take && (|rsel[9:6]) |=> rdata_q[31:8] == 24'h00_0000)
        else $error("reserved divider bits not zero");
    a_div_reset_vals: assert property (@(posedge clk_sys) disable iff (rst)
        $past(rst) |-> (div_q[0] == 8'h00) && (div_q[1] == 8'h01)
        && (div_q[2] == 8'h00) && (div_q[3] == 8'h00))
        else $error("divider reset value wrong");
    a_write_resp_time: assert property (@(posedge clk_sys) disable iff (rst)
        aw_take && w_take |=> ##1 bvalid_q)
        else $error("write response late");

    c_set_write: cover property (@(posedge clk_sys) disable iff (rst) wsel[2] || wsel[3]);
    c_clear_write: cover property (@(posedge clk_sys) disable iff (rst) wsel[4] || wsel[5]);
    c_div_read: cover property (@(posedge clk_sys) disable iff (rst) ar_take && (|rsel[9:6]));
    c_sys_tick_run: cover property (@(posedge clk_sys) disable iff (rst)
        sys_clk_en ##1 !sys_clk_en ##2 sys_clk_en);
endmodule

// *** verif/peripheral_clock_gate_and_dividers_bench.sv ***
// Self-checking bench of the peripheral clock gates and dividers
`timescale 1ns/1ps
`include "clk_ctl_map.svh"
module peripheral_clock_gate_and_dividers_bench;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [31:0] awaddr = 32'h0000_0000;
    logic [31:0] wdata = 32'h0000_0000;
    logic [31:0] araddr = 32'h0000_0000;
    logic [3:0] wstrb = 4'h0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic [3:0] strb = 4'hf;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata, gate_zero, gate_one;
    logic tick_timer_clk_en, sys_clk_en, converter_clk_en, external_clock_output;
    wire [3:0] clk_en = {external_clock_output, converter_clk_en, sys_clk_en, tick_timer_clk_en};
    logic [31:0] div_addr [4] = '{`TICK_DIV_ADDR, `SYS_DIV_ADDR, `CONV_DIV_ADDR, `EXTERNAL_CLOCK_OUTPUT_DIV_ADDR};
    logic [7:0] div_rst [4] = '{`TICK_DIV_RESET, `SYS_DIV_RESET, `CONV_DIV_RESET, `EXTERNAL_CLOCK_OUTPUT_DIV_RESET};
    int errors = 0;
    int checks_done = 0;

    peripheral_clock_gate_and_dividers u_peripheral_clock_gate_and_dividers (
        .clk_sys(clk_sys), .rst(rst),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .gate_zero(gate_zero), .gate_one(gate_one),
        .tick_timer_clk_en(tick_timer_clk_en), .sys_clk_en(sys_clk_en),
        .converter_clk_en(converter_clk_en), .external_clock_output(external_clock_output)
    );

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic axi_write(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        r = 2'h3;
        awaddr <= a;
        wdata <= d;
        wstrb <= strb;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge clk_sys);
            n++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid === 1'b1) begin
                r = bresp;
                break;
            end
            if (n > 200) begin
                check(1'b0, 1'b1, "write hang");
                break;
            end
        end
        bready <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic axi_read(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        r = 2'h3;
        d = 32'hdead_beef;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge clk_sys);
            n++;
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid === 1'b1) begin
                r = rresp;
                d = rdata;
                break;
            end
            if (n > 200) begin
                check(1'b0, 1'b1, "read hang");
                break;
            end
        end
        rready <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic wait_pulse(input int i, output int k);
        k = 0;
        do begin
            @(posedge clk_sys);
            k++;
        end while (clk_en[i] !== 1'b1 && k < 700);
    endtask

    task automatic count_pulses(input int i, input int len, output int cnt);
        cnt = 0;
        repeat (len) begin
            @(posedge clk_sys);
            if (clk_en[i] !== 1'b0) cnt++;
        end
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic test_reset;
        logic [31:0] d;
        logic [1:0] r;
        int k;
        check(gate_zero, `GATE_ZERO_RESET, "gate zero reset");
        check(gate_one, `GATE_ONE_RESET, "gate one reset");
        for (int i = 0; i < 4; i++) begin
            axi_read(div_addr[i], d, r);
            check(d, {24'h00_0000, div_rst[i]}, "divider reset");
        end
        wait_pulse(1, k);
        wait_pulse(1, k);
        check(32'(k), 32'h0000_0001, "system clock at reset");
        for (int i = 0; i < 4; i++) begin
            if (i != 1) begin
                count_pulses(i, 40, k);
                check(32'(k), 32'h0000_0000, "stopped at reset");
            end
        end
    endtask

    task automatic test_gates;
        logic [31:0] ops_a [7] = '{`GATE_ZERO_SET_ADDR, `GATE_ZERO_CLR_ADDR, `GATE_ONE_SET_ADDR,
            `GATE_ONE_CLR_ADDR, `GATE_ZERO_CLR_ADDR, `GATE_ONE_SET_ADDR, `GATE_ZERO_SET_ADDR};
        logic [31:0] ops_d [7] = '{32'hffff_ffff, 32'h0000_0108, 32'hffff_ffff, 32'h0000_0401,
            32'hffff_ffff, 32'h0000_0400, 32'h0000_0182};
        logic [31:0] z, o, d;
        logic [1:0] r;
        z = `GATE_ZERO_RESET;
        o = `GATE_ONE_RESET;
        for (int j = 0; j < 7; j++) begin
            axi_write(ops_a[j], ops_d[j], r);
            check(r, 2'h0, "gate write resp");
            case (ops_a[j])
                `GATE_ZERO_SET_ADDR: z = z | (ops_d[j] & `GATE_ZERO_MASK);
                `GATE_ZERO_CLR_ADDR: z = z & ~(ops_d[j] & `GATE_ZERO_MASK);
                `GATE_ONE_SET_ADDR: o = o | (ops_d[j] & `GATE_ONE_MASK);
                default: o = o & ~(ops_d[j] & `GATE_ONE_MASK);
            endcase
            check(gate_zero, z, "gate zero");
            check(gate_one, o, "gate one");
        end
        for (int j = 0; j < 4; j++) begin
            axi_read(ops_a[j], d, r);
            check(d, 32'h0000_0000, "write-only read data");
            check(r, 2'h0, "write-only read resp");
            check(gate_zero, z, "gate zero kept");
            check(gate_one, o, "gate one kept");
        end
        axi_read(`GATE_ZERO_ADDR, d, r);
        check(d, z, "gate zero read");
        axi_read(`GATE_ONE_ADDR, d, r);
        check(d, o, "gate one read");
        axi_write(32'h4000_00f0, 32'hffff_ffff, r);
        check(r, 2'h2, "unmapped write resp");
        check(gate_zero, z, "unmapped write gate");
        check(gate_one, o, "unmapped write gate one");
        axi_read(32'h4000_00f0, d, r);
        check(r, 2'h2, "unmapped read resp");
        check(d, 32'h0000_0000, "unmapped read data");
    endtask

    task automatic run_div(input int i, input logic [7:0] old, input logic [7:0] n);
        logic [31:0] d;
        logic [1:0] r;
        int k;
        int lo;
        int g;
        int m;
        lo = (old == 8'h00 || n < old) ? n : old;
        m = 1000;
        fork
            axi_write(div_addr[i], {24'h00_0000, n}, r);
            if (old != 8'h00 && n != 8'h00) begin
                wait_pulse(i, g);
                repeat (3) begin
                    wait_pulse(i, g);
                    m = (g < m) ? g : m;
                end
            end
        join
        check(r, 2'h0, "divider write resp");
        check(32'(m >= lo), 32'h0000_0001, "short gap on change");
        axi_read(div_addr[i], d, r);
        check(d, {24'h00_0000, n}, "divider readback");
        if (n == 8'h00) begin
            repeat (300) @(posedge clk_sys);
            count_pulses(i, 300, k);
            check(32'(k), 32'h0000_0000, "stopped clock");
        end else begin
            wait_pulse(i, k);
            wait_pulse(i, k);
            check(32'(k), {24'h00_0000, n}, "divided period");
        end
    endtask

    task automatic test_dividers;
        logic [7:0] vals [4] = '{8'h01, 8'h03, 8'hff, 8'h00};
        logic [7:0] old;
        logic [31:0] d;
        logic [1:0] r;
        for (int i = 0; i < 4; i++) begin
            old = div_rst[i];
            foreach (vals[v]) begin
                run_div(i, old, vals[v]);
                old = vals[v];
            end
        end
        strb = 4'he;
        axi_write(div_addr[3], 32'h0000_0055, r);
        strb = 4'hf;
        check(r, 2'h0, "masked lane write resp");
        axi_read(div_addr[3], d, r);
        check(d, 32'h0000_0000, "divider kept on masked lane");
    endtask

    task automatic wrap_up;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Clock, sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        forever #4 clk_sys = ~clk_sys;
    end

    initial begin
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        test_reset;
        test_gates;
        test_dividers;
        wrap_up;
    end

    initial begin
        repeat (40000) @(posedge clk_sys);
        errors++;
        $display("mismatch at %0t: watchdog expired", $time);
        wrap_up;
    end
endmodule
